// *** rtl/hpm_host_port.sv ***
`timescale 1ns/1ps
`include "hpm_regs.svh"
module hpm_host_port #(
    parameter int DW = 16,  // data width
    parameter int AW = 14   // word address width
) (
    input  wire logic            CLOCK,          // 250 MHz clock
    input  wire logic            RST_B,          // async reset, active low
    input  wire logic            ADDR_STROBE_N,  // address latch strobe
    input  wire logic            COMBINED_HOST_STROBE_N, // host strobe
    input  wire logic            ACCESS_SELECT_HI, // select bit 1
    input  wire logic            ACCESS_SELECT_LO, // select bit 0
    input  wire logic            READ_NOT_WRITE, // 1 read, 0 write
    input  wire logic            HIGH_BYTE_LANE_ENABLE_N, // high lane, low
    input  wire logic            LOW_BYTE_LANE_ENABLE_N,  // low lane, low
    input  wire logic [DW-1:0]   HOST_DATA_BUS_IN,  // bus from host
    output logic      [DW-1:0]   HOST_DATA_BUS_OUT, // bus to host
    output logic      [1:0]      HOST_DATA_BUS_OE,  // per byte drive
    output logic                 HOST_READY,     // host cycle may end
    input  wire logic [AW-1:0]   HOST_ADDRESS_PINS, // unused here
    input  wire logic            BOOT_STRAP_PIN, // mode strap
    input  wire logic [1:0]      BUS_SELECT_MODE, // mode field of bus select
    input  wire logic            HOST_KEEPS_CLOCK_AWAKE, // keep-awake bit
    input  wire logic            CLKGEN_IDLE,    // clock domain idle
    input  wire logic            DMA_IDLE,       // transfer domain idle
    input  wire logic            EMU_HALT,       // emulation halt
    input  wire logic            DMA_FREE,       // run-during-halt bit
    input  wire logic            CORE_STATUS_IRQ_WR, // core writes status bit
    input  wire logic            CORE_STATUS_IRQ_DATA, // value written
    output logic                 CORE_STATUS_IRQ, // status bit value
    output logic                 CORE_TO_HOST_IRQ_N, // interrupt to host
    output logic                 HOST_TO_CORE_IRQ, // one-cycle pulse
    output logic                 CLKGEN_STAY_AWAKE, // block clock idle
    output logic                 MUX_MODE,       // multiplexed mode on
    output logic                 MEM_REQ_VALID,  // memory request
    input  wire logic            MEM_REQ_READY,  // memory takes it
    output logic                 MEM_REQ_WRITE,  // 1 write
    output logic      [AW-1:0]   MEM_REQ_ADDR,   // word address
    output logic      [DW-1:0]   MEM_REQ_WDATA,  // write data
    output logic      [1:0]      MEM_REQ_BE,     // byte lanes
    input  wire logic            MEM_RSP_VALID,  // read data valid
    input  wire logic [DW-1:0]   MEM_RSP_RDATA   // read data
);
    import hpm_pkg::*;

    // ----------------------------------------------------------------
    // strobe edges and select capture
    // ----------------------------------------------------------------
    logic        has_d_ff, nxt_has_d;
    logic        stb_d_ff, nxt_stb_d;
    logic [1:0]  sel_ff, nxt_sel;
    logic        rnw_ff, nxt_rnw;
    logic        has_used_ff, nxt_has_used;
    logic        has_fall, stb_fall, stb_rise;

    assign has_fall = has_d_ff & ~ADDR_STROBE_N;
    assign stb_fall = stb_d_ff & ~COMBINED_HOST_STROBE_N;
    assign stb_rise = ~stb_d_ff & COMBINED_HOST_STROBE_N;

    always_comb begin
        nxt_has_d    = ADDR_STROBE_N;
        nxt_stb_d    = COMBINED_HOST_STROBE_N;
        nxt_sel      = sel_ff;
        nxt_rnw      = rnw_ff;
        nxt_has_used = has_used_ff;
        if (has_fall) begin
            nxt_has_used = 1'b1;
            nxt_sel      = {ACCESS_SELECT_HI, ACCESS_SELECT_LO};
            nxt_rnw      = READ_NOT_WRITE;
        end else if (stb_fall && !has_used_ff) begin
            nxt_sel = {ACCESS_SELECT_HI, ACCESS_SELECT_LO};
            nxt_rnw = READ_NOT_WRITE;
        end
        if (stb_rise)
            nxt_has_used = 1'b0;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            has_d_ff    <= 1'b1;
            stb_d_ff    <= 1'b1;
            sel_ff      <= 2'h0;
            rnw_ff      <= 1'b1;
            has_used_ff <= 1'b0;
        end else begin
            has_d_ff    <= nxt_has_d;
            stb_d_ff    <= nxt_stb_d;
            sel_ff      <= nxt_sel;
            rnw_ff      <= nxt_rnw;
            has_used_ff <= nxt_has_used;
        end
    end

    // effective select for this strobe: fresh pins unless latched by HAS
    logic [1:0] cur_sel;
    logic       cur_rnw;
    assign cur_sel = has_used_ff ? sel_ff
                                 : {ACCESS_SELECT_HI, ACCESS_SELECT_LO};
    assign cur_rnw = has_used_ff ? rnw_ff : READ_NOT_WRITE;

    // ----------------------------------------------------------------
    // mode, power and interrupts
    // ----------------------------------------------------------------
    logic strap_low_ff, nxt_strap_low;
    logic strap_taken_ff, nxt_strap_taken;
    logic stat_ff, nxt_stat;
    logic irq_ff, nxt_irq;

    always_comb begin
        nxt_strap_taken = 1'b1;
        nxt_strap_low   = strap_low_ff;
        nxt_stat        = stat_ff;
        if (!strap_taken_ff)
            nxt_strap_low = ~BOOT_STRAP_PIN;
        if (CORE_STATUS_IRQ_WR)
            nxt_stat = CORE_STATUS_IRQ_DATA;
    end

    assign MUX_MODE = strap_low_ff
                    | (BUS_SELECT_MODE == `HPM_MODE_MUX);
    assign CLKGEN_STAY_AWAKE  = ~HOST_KEEPS_CLOCK_AWAKE;
    assign CORE_TO_HOST_IRQ_N = stat_ff;
    assign CORE_STATUS_IRQ    = stat_ff;

    // ----------------------------------------------------------------
    // host cycle sequencer
    // ----------------------------------------------------------------
    hpm_state_t st_ff, nxt_st;
    hpm_word_t  shadow_ff, nxt_shadow;  // not initialised
    hpm_addr_t  addr_ff, nxt_addr;      // not initialised
    hpm_word_t  hold_ff, nxt_hold;      // not initialised
    logic       inc_ff, nxt_inc;
    logic       wr_ff, nxt_wr;
    logic [1:0] be_ff, nxt_be;
    logic       mem_ok, is_data;

    // ----------------------------------------------------------------
    // memory access gating
    // ----------------------------------------------------------------

    assign is_data = cur_sel[0];  // 01 and 11 are data selects
    assign mem_ok  = ~CLKGEN_IDLE & ~DMA_IDLE
                   & (~EMU_HALT | DMA_FREE);

    always_comb begin
        nxt_st     = st_ff;
        nxt_shadow = shadow_ff;
        nxt_addr   = addr_ff;
        nxt_hold   = hold_ff;
        nxt_inc    = inc_ff;
        nxt_wr     = wr_ff;
        nxt_be     = be_ff;
        nxt_irq    = 1'b0;
        case (st_ff)
            HPM_IDLE: begin
                if (stb_fall && MUX_MODE) begin
                    nxt_be = {~HIGH_BYTE_LANE_ENABLE_N,
                              ~LOW_BYTE_LANE_ENABLE_N};
                    case (cur_sel)
                        `HPM_SEL_CTRL: begin
                            if (!cur_rnw &&
                                HOST_DATA_BUS_IN[`HPM_CTRL_IRQ_BIT])
                                nxt_irq = 1'b1;
                            nxt_st = HPM_DONE;
                        end
                        `HPM_SEL_ADDR: begin
                            if (!cur_rnw) begin
                                nxt_shadow = HOST_DATA_BUS_IN;
                                nxt_addr   =
                                    HOST_DATA_BUS_IN[AW-1:0];
                            end
                            nxt_st = HPM_DONE;
                        end
                        default: begin
                            nxt_inc  = (cur_sel == `HPM_SEL_DATA_INC);
                            nxt_wr   = ~cur_rnw;
                            nxt_hold = HOST_DATA_BUS_IN;
                            nxt_st   = HPM_REQ;
                        end
                    endcase
                end
            end
            HPM_REQ: begin
                if (mem_ok && MEM_REQ_READY)
                    nxt_st = wr_ff ? HPM_DONE : HPM_WAIT;
            end
            HPM_WAIT: begin
                if (MEM_RSP_VALID) begin
                    nxt_hold = MEM_RSP_RDATA;
                    nxt_st   = HPM_DONE;
                end
            end
            HPM_DONE: begin
                if (stb_rise) begin
                    if (inc_ff && be_ff[1]) begin
                        if (addr_ff == `HPM_ADDR_LAST)
                            nxt_addr = `HPM_ADDR_FIRST;
                        else
                            nxt_addr = addr_ff + 14'h0001;
                    end
                    nxt_inc = 1'b0;
                    nxt_st  = HPM_IDLE;
                end
            end
            default: nxt_st = HPM_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // control state registers
    // ----------------------------------------------------------------

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            strap_low_ff   <= 1'b0;
            strap_taken_ff <= 1'b0;
            stat_ff        <= 1'b1;
            irq_ff         <= 1'b0;
            st_ff          <= HPM_IDLE;
            inc_ff         <= 1'b0;
            wr_ff          <= 1'b0;
            be_ff          <= 2'h0;
        end else begin
            strap_low_ff   <= nxt_strap_low;
            strap_taken_ff <= nxt_strap_taken;
            stat_ff        <= nxt_stat;
            irq_ff         <= nxt_irq;
            st_ff          <= nxt_st;
            inc_ff         <= nxt_inc;
            wr_ff          <= nxt_wr;
            be_ff          <= nxt_be;
        end
    end

    // ----------------------------------------------------------------
    // address and data contents, not reset
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        shadow_ff <= nxt_shadow;
        addr_ff   <= nxt_addr;
        hold_ff   <= nxt_hold;
    end

    // ----------------------------------------------------------------
    // outputs; ready only in the done state
    // ----------------------------------------------------------------
    assign HOST_TO_CORE_IRQ = irq_ff;
    assign MEM_REQ_VALID    = (st_ff == HPM_REQ) & mem_ok;
    assign MEM_REQ_WRITE    = wr_ff;
    assign MEM_REQ_ADDR     = addr_ff;
    assign MEM_REQ_WDATA    = hold_ff;
    assign MEM_REQ_BE       = be_ff;
    assign HOST_READY       = (st_ff == HPM_DONE);

    // ----------------------------------------------------------------
    // host read data and lane drive
    // ----------------------------------------------------------------

    always_comb begin
        HOST_DATA_BUS_OUT = hold_ff;
        case (cur_sel)
            `HPM_SEL_CTRL:
                HOST_DATA_BUS_OUT = `HPM_CTRL_RESET;
            `HPM_SEL_ADDR: HOST_DATA_BUS_OUT = shadow_ff;
            default:       HOST_DATA_BUS_OUT = hold_ff;
        endcase
        HOST_DATA_BUS_OE = (!COMBINED_HOST_STROBE_N && cur_rnw
                            && st_ff == HPM_DONE) ? nxt_be_or(be_ff, is_data)
                                                  : 2'h0;
    end

    // ----------------------------------------------------------------
    // lane drive helper
    // ----------------------------------------------------------------
    function automatic logic [1:0] nxt_be_or(input logic [1:0] be,
                                             input logic dat);
        nxt_be_or = dat ? be : 2'h3;
    endfunction
endmodule

// *** shared/hpm_regs.svh ***
`ifndef HPM_REGS_SVH
`define HPM_REGS_SVH
// host access select codes
`define HPM_SEL_CTRL       2'h0
`define HPM_SEL_DATA_INC   2'h1
`define HPM_SEL_ADDR       2'h2
`define HPM_SEL_DATA_FIX   2'h3
// control word fields
`define HPM_CTRL_IRQ_BIT   1
`define HPM_CTRL_RESET     16'h0000
// bus select mode field
`define HPM_MODE_MUX       2'h3
// address layout
`define HPM_ADDR_W         14
`define HPM_ADDR_LAST      14'h3FFF
`define HPM_ADDR_FIRST     14'h0000
`endif

// *** shared/hpm_pkg.sv ***
package hpm_pkg;
    typedef enum logic [1:0] {
        HPM_IDLE = 2'b00,
        HPM_REQ  = 2'b01,
        HPM_DONE = 2'b11,
        HPM_WAIT = 2'b10
    } hpm_state_t;
    typedef logic [15:0] hpm_word_t;
    typedef logic [13:0] hpm_addr_t;
endpackage

// *** test/hpm_host_port_asserts.sv ***
`timescale 1ns/1ps
// ----
// port checker
// ----
module hpm_host_port_chk (
    input wire logic       CLOCK,                  // clock
    input wire logic       RST_B,                  // reset
    input wire logic       COMBINED_HOST_STROBE_N, // strobe
    input wire logic       HOST_READY,             // done
    input wire logic       HOST_KEEPS_CLOCK_AWAKE, // keep bit
    input wire logic       CLKGEN_STAY_AWAKE,      // awake
    input wire logic       CLKGEN_IDLE,            // idle
    input wire logic       DMA_IDLE,               // idle
    input wire logic       EMU_HALT,               // halt
    input wire logic       DMA_FREE,               // free run
    input wire logic       MEM_REQ_VALID,          // request
    input wire logic       MEM_REQ_READY,          // accept
    input wire logic       CORE_STATUS_IRQ_WR,     // write
    input wire logic       CORE_STATUS_IRQ_DATA,   // value
    input wire logic       CORE_TO_HOST_IRQ_N,     // to host
    input wire logic       HOST_TO_CORE_IRQ,       // to core
    input wire logic [1:0] BUS_SELECT_MODE,        // mode
    input wire logic       MUX_MODE                // mux on
);
default clocking @(posedge CLOCK); endclocking
default disable iff (!RST_B);
property p_irq_follow;
    CORE_STATUS_IRQ_WR |=> CORE_TO_HOST_IRQ_N == $past(CORE_STATUS_IRQ_DATA);
endproperty
a_irq_follow: assert property (p_irq_follow)
    else $error("irq pin off");
property p_irq_reset;
    $rose(RST_B) |-> CORE_TO_HOST_IRQ_N;
endproperty
a_irq_reset: assert property (p_irq_reset)
    else $error("irq pin active at reset");
property p_awake;
    CLKGEN_STAY_AWAKE == !HOST_KEEPS_CLOCK_AWAKE;
endproperty
a_awake: assert property (p_awake)
    else $error("awake request wrong");
property p_idle;
    CLKGEN_IDLE || DMA_IDLE |-> !(MEM_REQ_VALID && MEM_REQ_READY);
endproperty
a_idle: assert property (p_idle)
    else $error("access while idle");
property p_halt;
    EMU_HALT && !DMA_FREE |-> !(MEM_REQ_VALID && MEM_REQ_READY);
endproperty
a_halt: assert property (p_halt)
    else $error("access while halted");
property p_mode;
    BUS_SELECT_MODE == 2'h3 |-> MUX_MODE;
endproperty
a_mode: assert property (p_mode)
    else $error("mode not selected");
property p_pulse;
    $rose(HOST_TO_CORE_IRQ) |=> !HOST_TO_CORE_IRQ;
endproperty
a_pulse: assert property (p_pulse)
    else $error("core irq too long");
property p_held;
    MEM_REQ_VALID |-> !HOST_READY;
endproperty
a_held: assert property (p_held)
    else $error("host released early");
property p_done;
    HOST_READY |-> !$past(COMBINED_HOST_STROBE_N);
endproperty
a_done: assert property (p_done)
    else $error("ready without strobe");
endmodule
bind hpm_host_port hpm_host_port_chk u_chk (.CLOCK, .RST_B,
    .COMBINED_HOST_STROBE_N, .HOST_READY, .HOST_KEEPS_CLOCK_AWAKE,
    .CLKGEN_STAY_AWAKE, .CLKGEN_IDLE, .DMA_IDLE, .EMU_HALT, .DMA_FREE,
    .MEM_REQ_VALID, .MEM_REQ_READY, .CORE_STATUS_IRQ_WR,
    .CORE_STATUS_IRQ_DATA, .CORE_TO_HOST_IRQ_N, .HOST_TO_CORE_IRQ,
    .BUS_SELECT_MODE, .MUX_MODE);

// *** test/hpm_mem_model.sv ***
`timescale 1ns/1ps
// ----
// dual access memory
// ----
module hpm_mem_model (
    input  wire logic        clock,     // clock
    input  wire logic        stall,     // refuse requests
    input  wire logic        req_valid, // request
    output logic             req_ready, // accept
    input  wire logic        req_write, // write
    input  wire logic [13:0] req_addr,  // address
    input  wire logic [15:0] req_wdata, // write data
    input  wire logic [1:0]  req_be,    // lanes
    output logic             rsp_valid, // read answer
    output logic [15:0]      rsp_rdata  // read data
);
logic [15:0] mem [0:16383];
assign req_ready = !stall;
initial begin
    rsp_valid = 1'b0;
    rsp_rdata = 16'h0000;
end
always @(posedge clock) begin
    rsp_valid <= 1'b0;
    rsp_rdata <= ~rsp_rdata; // no stale data between answers
    if (req_valid && req_ready && req_write) begin
        if (req_be[0]) mem[req_addr][7:0] <= req_wdata[7:0];
        if (req_be[1]) mem[req_addr][15:8] <= req_wdata[15:8];
    end else if (req_valid && req_ready) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= mem[req_addr];
    end
end
endmodule

// *** test/test_host_port_multiplexed_access.sv ***
`timescale 1ns/1ps
`include "hpm_regs.svh"
module test_host_port_multiplexed_access;
// ----
// signals
// ----
logic        CLOCK, RST_B, ADDR_STROBE_N, COMBINED_HOST_STROBE_N, stall;
logic        ACCESS_SELECT_HI, ACCESS_SELECT_LO, READ_NOT_WRITE;
logic        HIGH_BYTE_LANE_ENABLE_N, LOW_BYTE_LANE_ENABLE_N, DMA_FREE;
logic        BOOT_STRAP_PIN, HOST_KEEPS_CLOCK_AWAKE, CLKGEN_IDLE;
logic        DMA_IDLE, EMU_HALT, CORE_STATUS_IRQ_WR, CORE_STATUS_IRQ_DATA;
logic        HOST_READY, CORE_STATUS_IRQ, CORE_TO_HOST_IRQ_N, MUX_MODE;
logic        HOST_TO_CORE_IRQ, CLKGEN_STAY_AWAKE, MEM_REQ_VALID;
logic        MEM_REQ_READY, MEM_REQ_WRITE, MEM_RSP_VALID;
logic [1:0]  BUS_SELECT_MODE, HOST_DATA_BUS_OE, MEM_REQ_BE;
logic [13:0] HOST_ADDRESS_PINS, MEM_REQ_ADDR;
logic [15:0] HOST_DATA_BUS_IN, HOST_DATA_BUS_OUT, MEM_REQ_WDATA;
logic [15:0] MEM_RSP_RDATA, sh, rd;
int          n_mismatch, n_compared, n_irq, ia, i, p, n0;
int          mem_e [0:16383];
logic [1:0]  tsel [0:5] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h1};
logic [1:0]  tben [0:5] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
hpm_host_port u_dut (.CLOCK, .RST_B, .ADDR_STROBE_N,
    .COMBINED_HOST_STROBE_N, .ACCESS_SELECT_HI, .ACCESS_SELECT_LO,
    .READ_NOT_WRITE, .HIGH_BYTE_LANE_ENABLE_N, .LOW_BYTE_LANE_ENABLE_N,
    .HOST_DATA_BUS_IN, .HOST_DATA_BUS_OUT, .HOST_DATA_BUS_OE, .HOST_READY,
    .HOST_ADDRESS_PINS, .BOOT_STRAP_PIN, .BUS_SELECT_MODE,
    .HOST_KEEPS_CLOCK_AWAKE, .CLKGEN_IDLE, .DMA_IDLE, .EMU_HALT, .DMA_FREE,
    .CORE_STATUS_IRQ_WR, .CORE_STATUS_IRQ_DATA, .CORE_STATUS_IRQ,
    .CORE_TO_HOST_IRQ_N, .HOST_TO_CORE_IRQ, .CLKGEN_STAY_AWAKE, .MUX_MODE,
    .MEM_REQ_VALID, .MEM_REQ_READY, .MEM_REQ_WRITE, .MEM_REQ_ADDR,
    .MEM_REQ_WDATA, .MEM_REQ_BE, .MEM_RSP_VALID, .MEM_RSP_RDATA);
hpm_mem_model u_mem (.clock(CLOCK), .stall, .req_valid(MEM_REQ_VALID),
    .req_ready(MEM_REQ_READY), .req_write(MEM_REQ_WRITE),
    .req_addr(MEM_REQ_ADDR), .req_wdata(MEM_REQ_WDATA),
    .req_be(MEM_REQ_BE), .rsp_valid(MEM_RSP_VALID),
    .rsp_rdata(MEM_RSP_RDATA));
// ----
// helpers
// ----
initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
end
always @(posedge CLOCK) if (HOST_TO_CORE_IRQ === 1'b1) n_irq++;
always @(negedge CLOCK) begin
    stall <= ($urandom_range(2, 0) == 0);
    HOST_ADDRESS_PINS <= 14'($urandom);
end
task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask
task automatic chk(input logic c, input string msg);
    n_compared++;
    if (c !== 1'b1) begin
        n_mismatch++;
        $display("CHECK FAILED %0t %s", $time, msg);
    end
endtask
task automatic host(input logic [1:0] sel, input logic rnw,
                    input logic [1:0] ben, input logic [15:0] wd);
    int k;
    logic [15:0] m;
    m = {{8{!ben[1]}}, {8{!ben[0]}}};
    @(negedge CLOCK);
    {ACCESS_SELECT_HI, ACCESS_SELECT_LO} = sel;
    {HIGH_BYTE_LANE_ENABLE_N, LOW_BYTE_LANE_ENABLE_N} = ben;
    READ_NOT_WRITE = rnw;
    HOST_DATA_BUS_IN = wd;
    COMBINED_HOST_STROBE_N = 1'b0;
    for (k = 0; k < 300 && HOST_READY !== 1'b1; k++) @(negedge CLOCK);
    if (k == 300) begin
        chk(1'b0, "no ready");
        report_and_stop();
    end
    rd = HOST_DATA_BUS_OUT;
    chk(HOST_DATA_BUS_OE === (rnw ? ~ben : 2'h0), "lane drive");
    COMBINED_HOST_STROBE_N = 1'b1;
    repeat (2) @(negedge CLOCK);
    if (sel == `HPM_SEL_ADDR && rnw) begin
        chk(rd === sh, "address read");
    end else if (sel == `HPM_SEL_ADDR) begin
        sh = wd;
        ia = int'(wd[13:0]);
    end else if (sel == `HPM_SEL_CTRL && rnw) begin
        chk(rd === 16'h0000, "control read");
    end else if (sel != `HPM_SEL_CTRL) begin
        if (rnw) chk((rd & m) === (mem_e[ia][15:0] & m), "data");
        else mem_e[ia][15:0] = (mem_e[ia][15:0] & ~m) | (wd & m);
        if (sel == `HPM_SEL_DATA_INC && !ben[1]) ia = (ia + 1) % 16384;
    end
endtask
// ----
// sequence
// ----
initial begin
    void'($urandom(32'hEF4B));
    {RST_B, COMBINED_HOST_STROBE_N, ADDR_STROBE_N} = 3'h3;
    {ACCESS_SELECT_HI, ACCESS_SELECT_LO, READ_NOT_WRITE} = 3'h0;
    {HIGH_BYTE_LANE_ENABLE_N, LOW_BYTE_LANE_ENABLE_N} = 2'h0;
    {BOOT_STRAP_PIN, HOST_KEEPS_CLOCK_AWAKE, CLKGEN_IDLE} = 3'h0;
    {DMA_IDLE, EMU_HALT, DMA_FREE, CORE_STATUS_IRQ_WR} = 4'h0;
    {CORE_STATUS_IRQ_DATA, BUS_SELECT_MODE} = 3'h0;
    HOST_DATA_BUS_IN = 16'h0000;
    repeat (5) @(negedge CLOCK);
    RST_B = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk(MUX_MODE === 1'b1, "strap mode");
    chk(CORE_TO_HOST_IRQ_N === 1'b1, "irq after reset");
    for (i = 0; i < 2; i++) begin
        CORE_STATUS_IRQ_WR = 1'b1;
        CORE_STATUS_IRQ_DATA = i[0];
        @(negedge CLOCK);
        CORE_STATUS_IRQ_WR = 1'b0;
        @(negedge CLOCK);
        chk(CORE_TO_HOST_IRQ_N === i[0], "irq pin");
        chk(CORE_STATUS_IRQ === i[0], "status bit");
    end
    for (p = 0; p < 2; p++) begin
        host(`HPM_SEL_ADDR, 1'b0, 2'h0, 16'h3FFE);
        for (i = 0; i < 6; i++) begin
            HOST_KEEPS_CLOCK_AWAKE = 1'($urandom);
            host(tsel[i], p[0], tben[i], 16'($urandom));
            chk(CLKGEN_STAY_AWAKE === !HOST_KEEPS_CLOCK_AWAKE, "awake");
        end
        host(`HPM_SEL_ADDR, 1'b1, 2'h0, 16'h0000);
    end
    n0 = n_irq;
    host(`HPM_SEL_CTRL, 1'b0, 2'h0, 16'h0002);
    host(`HPM_SEL_CTRL, 1'b0, 2'h0, 16'h0000);
    host(`HPM_SEL_CTRL, 1'b1, 2'h0, 16'h0000);
    chk(n_irq == n0 + 1, "one core irq");
    host(`HPM_SEL_ADDR, 1'b0, 2'h0, 16'h0001);
    {BUS_SELECT_MODE, DMA_IDLE, CLKGEN_IDLE, EMU_HALT} = 5'h1F;
    fork
        host(`HPM_SEL_DATA_FIX, 1'b1, 2'h0, 16'h0000);
        begin
            repeat (20) @(negedge CLOCK);
            chk(HOST_READY === 1'b0, "idle stall");
            {DMA_IDLE, CLKGEN_IDLE} = 2'h0;
            repeat (20) @(negedge CLOCK);
            chk(HOST_READY === 1'b0, "halt stall");
            DMA_FREE = 1'b1;
        end
    join
    CORE_STATUS_IRQ_WR = 1'b1;
    CORE_STATUS_IRQ_DATA = 1'b0;
    @(negedge CLOCK);
    {CORE_STATUS_IRQ_WR, BUS_SELECT_MODE, BOOT_STRAP_PIN} = 4'h1;
    RST_B = 1'b0;
    @(negedge CLOCK);
    chk(CORE_TO_HOST_IRQ_N === 1'b1, "irq in reset");
    repeat (4) @(negedge CLOCK);
    RST_B = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk(MUX_MODE === 1'b0, "strap high");
    n0 = n_irq;
    {ACCESS_SELECT_HI, ACCESS_SELECT_LO, READ_NOT_WRITE} = 3'h0;
    HOST_DATA_BUS_IN = 16'h0002;
    COMBINED_HOST_STROBE_N = 1'b0;
    repeat (3) @(negedge CLOCK);
    chk(HOST_READY === 1'b0 && n_irq == n0, "strobe outside mode");
    COMBINED_HOST_STROBE_N = 1'b1;
    @(negedge CLOCK);
    BUS_SELECT_MODE = `HPM_MODE_MUX;
    @(negedge CLOCK);
    chk(MUX_MODE === 1'b1, "mode field");
    host(`HPM_SEL_CTRL, 1'b1, 2'h0, 16'h0000);
    report_and_stop();
end
endmodule
